/* arp_regs.vh */
// Purpose: constants for the auto-reclose shot policy block
// Assumes: 32-bit APB, byte addresses, one register per aligned word
// Notes:   delays are counted in 0.01 s steps of the shared step tick
`ifndef ARP_REGS_VH
`define ARP_REGS_VH

// register byte offsets
`define ARP_CTRL_OFF      8'h00
`define ARP_FAST_MASK_OFF 8'h04
`define ARP_PH_FAST_OFF   8'h08
`define ARP_EF_FAST_OFF   8'h0C
`define ARP_DEAD_OFF      8'h10
`define ARP_RECLAIM_OFF   8'h14
`define ARP_RECLOSE_OFF   8'h18
`define ARP_INHIBIT_OFF   8'h1C
`define ARP_STATUS_OFF    8'h20
`define ARP_IRQ_STAT_OFF  8'h24
`define ARP_IRQ_CLR_OFF   8'h28
`define ARP_IRQ_EN_OFF    8'h2C

// control fields
`define ARP_CTRL_ENABLE   0
`define ARP_CTRL_DEADMODE 1
`define ARP_CTRL_UNLOCK   2
// fast mask fields
`define ARP_PH_MASK_LSB   0
`define ARP_EF_MASK_LSB   8
// status fields
`define ARP_ST_STATE_LSB  0
`define ARP_ST_SHOT_LSB   4
`define ARP_ST_LOCK_BIT   8
// interrupt event bits
`define ARP_EV_TRIP       0
`define ARP_EV_RECLOSE    1
`define ARP_EV_LOCKOUT    2
`define ARP_EV_SEQRESET   3

// reset values
`define ARP_FAST_RST      5'h00
`define ARP_MASK4_RST     32'h0000_0000
`define ARP_FDLY_RST      10'h000
`define ARP_DEAD_RST      16'h0014
`define ARP_RECLAIM_RST   16'h00C8
`define ARP_FDLY_MAX      10'h3E7

// timing: step of every delay setting and the system clock period
`define ARP_STEP_NS       10000000
`define ARP_CLK_NS        25

`endif

/* arp_step_timer.v */
// Purpose: delay timer counting 0.01 s steps up to a programmed limit
// Assumes: step_tick is a one-cycle pulse on clk_sys
// Notes:   limit of zero expires in the same cycle run is raised
`timescale 1ns/1ps
`default_nettype none

module arp_step_timer #(
    parameter WIDTH = 16
) (
    // clock and reset
    input  wire             clk_sys,
    input  wire             resetn,
    // control
    input  wire             run,
    input  wire             step_tick,
    input  wire [WIDTH-1:0] limit,
    // result
    output wire             expired
);

    reg  [WIDTH-1:0] count_q;
    reg  [WIDTH-1:0] count_d;

    // count held while expired so the compare stays true
    always @* begin
        count_d = count_q;
        if (!run) begin
            count_d = {WIDTH{1'b0}};
        end else if (step_tick && count_q < limit) begin
            count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_sys) begin
        if (!resetn) begin
            count_q <= {WIDTH{1'b0}};
        end else begin
            count_q <= count_d;
        end
    end

    assign expired = run && (count_q >= limit);

endmodule
`default_nettype wire

/* arp_shot_policy.v */
// Purpose: per-shot fast-trip, reclose and inhibit policy of the auto-recloser
// Assumes: stage inputs come from protection logic on clk_sys; breaker aux is a pin
// Notes:   stage order 0..7: phase one..three, earth one..three, aux one, aux two
//
// Overview of operation
// - five-bit phase fast-trip mask, one bit per trip, reset zero, used while running.
// - a set phase fast bit times the phase trip on the fast delay.
// - if the element delay is shorter, trip on whichever timer ends first.
// - mask bit zero governs the first trip, bit four the fifth.
// - fast delays programmable 0 to 9.99 s in 0.01 s steps, reset zero.
// - separate five-bit earth fast-trip mask, reset zero, used while running.
// - earth fast trip still trips on a shorter definite-time delay.
// - each stage has a four-bit reclose mask, one bit per cycle, reset zero.
// - a zero reclose bit makes the trip final and locks the recloser out.
// - a one reclose bit issues the reclose command after the dead time.
// - each stage has a four-bit inhibit mask, one bit per reclosing shot.
// - a set inhibit bit suppresses that stage trip after that shot.
// - reclaim timeout resets the sequence; a trip inside it advances or locks.
// - dead time starts on breaker aux drop or on protection reset, as set.
`timescale 1ns/1ps
`default_nettype none
`include "arp_regs.vh"

module arp_shot_policy #(
    parameter NSTAGE      = 8,
    parameter NSHOT       = 5,
    parameter NCYCLE      = 4,
    parameter TICK_CYCLES = `ARP_STEP_NS / `ARP_CLK_NS
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        resetn,
    // apb slave
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // protection elements
    input  wire [7:0]  stage_start,
    input  wire [7:0]  stage_delay_done,
    input  wire        breaker_closed_aux_input,
    // results
    output reg  [7:0]  stage_trip_q,
    output reg         reclose_cmd_q,
    output wire        ar_locked,
    output wire        irq
);

    // sequencer states
    localparam [2:0] ST_IDLE    = 3'h0;
    localparam [2:0] ST_TRIPPED = 3'h1;
    localparam [2:0] ST_DEAD    = 3'h2;
    localparam [2:0] ST_RECLAIM = 3'h3;
    localparam [2:0] ST_LOCKED  = 3'h4;

    // settings
    reg        ar_enable_q;
    reg        dead_mode_q;
    reg  [4:0] ph_fast_mask_q;
    reg  [4:0] ef_fast_mask_q;
    reg  [9:0] ph_fast_dly_q;
    reg  [9:0] ef_fast_dly_q;
    reg [15:0] dead_time_q;
    reg [15:0] reclaim_q;
    reg [31:0] reclose_mask_q;
    reg [31:0] inhibit_mask_q;
    reg  [3:0] irq_stat_q;
    reg  [3:0] irq_en_q;
    // sequence state
    reg  [2:0] state_q;
    reg  [2:0] state_d;
    reg  [2:0] shot_q;
    reg  [2:0] shot_d;
    reg        brk_meta_q;
    reg        brk_sync_q;
    reg [18:0] tick_cnt_q;
    reg        tick_q;

    // picks one bit of a stage's 4-bit field in a packed per-stage mask
    function stage_bit;
        input [31:0] word;
        input [2:0]  stage;
        input [1:0]  idx;
        begin
            stage_bit = word[stage*4 + idx];
        end
    endfunction

    // lowest set bit of a stage vector
    function [2:0] first_stage;
        input [7:0] vec;
        integer i;
        begin
            first_stage = 3'h0;
            for (i = 7; i >= 0; i = i - 1) begin
                if (vec[i]) begin
                    first_stage = i[2:0];
                end
            end
        end
    endfunction

    // apb decode; zero wait states, error on unmapped offsets
    wire apb_wr = psel && penable && pwrite;
    wire apb_rd = psel && !pwrite;
    reg  addr_ok;
    always @* begin
        case (paddr)
            `ARP_CTRL_OFF, `ARP_FAST_MASK_OFF, `ARP_PH_FAST_OFF, `ARP_EF_FAST_OFF,
            `ARP_DEAD_OFF, `ARP_RECLAIM_OFF, `ARP_RECLOSE_OFF, `ARP_INHIBIT_OFF,
            `ARP_STATUS_OFF, `ARP_IRQ_STAT_OFF, `ARP_IRQ_CLR_OFF,
            `ARP_IRQ_EN_OFF: addr_ok = 1'b1;
            default:         addr_ok = 1'b0;
        endcase
    end
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    wire wr_ok = apb_wr && addr_ok;

    // 0.01 s step tick shared by every timer
    always @(posedge clk_sys) begin
        if (!resetn) begin
            tick_cnt_q <= 19'h00000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TICK_CYCLES - 1) begin
            tick_cnt_q <= 19'h00000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 19'h00001;
            tick_q     <= 1'b0;
        end
    end

    // recloser is live only when enabled and not locked out
    wire       ar_run     = ar_enable_q && (state_q != ST_LOCKED);
    wire       in_reclaim = (state_q == ST_RECLAIM);
    wire [2:0] shot_idx   = (shot_q == 3'h0) ? 3'h0 : shot_q - 3'h1;
    // fast bit for the coming trip; bit zero is the first trip
    wire ph_fast_sel = ar_run && (shot_q < NSHOT) && ph_fast_mask_q[shot_q];
    wire ef_fast_sel = ar_run && (shot_q < NSHOT) && ef_fast_mask_q[shot_q];

    // fast timers run while any stage of their group is started
    wire ph_fast_done;
    wire ef_fast_done;
    arp_step_timer #(.WIDTH(10)) u_ph_fast (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .run       (ph_fast_sel && |stage_start[2:0]),
        .step_tick (tick_q),
        .limit     (ph_fast_dly_q),
        .expired   (ph_fast_done)
    );
    arp_step_timer #(.WIDTH(10)) u_ef_fast (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .run       (ef_fast_sel && |stage_start[5:3]),
        .step_tick (tick_q),
        .limit     (ef_fast_dly_q),
        .expired   (ef_fast_done)
    );

    // per-stage trip: shorter of element or fast delay, then last shot's inhibit
    reg [7:0] trip_d;
    integer   s;
    always @* begin
        trip_d = 8'h00;
        for (s = 0; s < NSTAGE; s = s + 1) begin
            trip_d[s] = stage_delay_done[s];
            if (s < 3) begin
                trip_d[s] = trip_d[s] | (stage_start[s] & ph_fast_done);
            end else if (s < 6) begin
                trip_d[s] = trip_d[s] | (stage_start[s] & ef_fast_done);
            end
            if (in_reclaim && stage_bit(inhibit_mask_q, s[2:0], shot_idx[1:0])) begin
                trip_d[s] = 1'b0;
            end
        end
    end

    // a new trip is the first cycle any stage trips
    wire       trip_new   = (trip_d != 8'h00) && (stage_trip_q == 8'h00);
    wire [2:0] trip_stage = first_stage(trip_d);
    wire       close_bit  = (shot_q < NCYCLE) &&
                            stage_bit(reclose_mask_q, trip_stage, shot_q[1:0]);
    // dead and reclaim timers
    wire dead_go   = dead_mode_q ? (stage_start == 8'h00) : !brk_sync_q;
    wire dead_done;
    wire reclaim_done;
    arp_step_timer #(.WIDTH(16)) u_dead (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .run       (state_q == ST_DEAD),
        .step_tick (tick_q),
        .limit     (dead_time_q),
        .expired   (dead_done)
    );
    arp_step_timer #(.WIDTH(16)) u_reclaim (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .run       (in_reclaim),
        .step_tick (tick_q),
        .limit     (reclaim_q),
        .expired   (reclaim_done)
    );

    // sequencer; trips in the tripped and dead states are not counted
    reg ev_reclose;
    reg ev_lockout;
    reg ev_reset;
    wire unlock = wr_ok && (paddr == `ARP_CTRL_OFF) && pwdata[`ARP_CTRL_UNLOCK];
    always @* begin
        state_d    = state_q;
        shot_d     = shot_q;
        ev_reclose = 1'b0;
        ev_lockout = 1'b0;
        ev_reset   = 1'b0;
        case (state_q)
            ST_IDLE, ST_RECLAIM: begin
                if (!ar_enable_q) begin
                    state_d = ST_IDLE;
                    shot_d  = 3'h0;
                end else if (trip_new) begin
                    shot_d = shot_q + 3'h1;
                    if (close_bit) begin
                        state_d = ST_TRIPPED;
                    end else begin
                        state_d    = ST_LOCKED;
                        shot_d     = 3'h0;
                        ev_lockout = 1'b1;
                    end
                end else if (in_reclaim && reclaim_done) begin
                    state_d  = ST_IDLE;
                    shot_d   = 3'h0;
                    ev_reset = 1'b1;
                end
            end
            ST_TRIPPED: begin
                if (!ar_enable_q) begin
                    state_d = ST_IDLE;
                    shot_d  = 3'h0;
                end else if (dead_go) begin
                    state_d = ST_DEAD;
                end
            end
            ST_DEAD: begin
                if (!ar_enable_q) begin
                    state_d = ST_IDLE;
                    shot_d  = 3'h0;
                end else if (dead_done) begin
                    state_d    = ST_RECLAIM;
                    ev_reclose = 1'b1;
                end
            end
            ST_LOCKED: begin
                if (unlock) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                shot_d  = 3'h0;
            end
        endcase
    end
    // sequence, trip and breaker sync flops
    always @(posedge clk_sys) begin
        if (!resetn) begin
            state_q       <= ST_IDLE;
            shot_q        <= 3'h0;
            reclose_cmd_q <= 1'b0;
            stage_trip_q  <= 8'h00;
            brk_meta_q    <= 1'b0;
            brk_sync_q    <= 1'b0;
        end else begin
            state_q       <= state_d;
            shot_q        <= shot_d;
            reclose_cmd_q <= ev_reclose;
            stage_trip_q  <= trip_d;
            brk_meta_q    <= breaker_closed_aux_input; // pin crosses in through two flops
            brk_sync_q    <= brk_meta_q;
        end
    end
    assign ar_locked = (state_q == ST_LOCKED);

    // settings writes; fast delays above 9.99 s clamp to the maximum
    always @(posedge clk_sys) begin
        if (!resetn) begin
            ar_enable_q    <= 1'b0;
            dead_mode_q    <= 1'b0;
            ph_fast_mask_q <= `ARP_FAST_RST;
            ef_fast_mask_q <= `ARP_FAST_RST;
            ph_fast_dly_q  <= `ARP_FDLY_RST;
            ef_fast_dly_q  <= `ARP_FDLY_RST;
            dead_time_q    <= `ARP_DEAD_RST;
            reclaim_q      <= `ARP_RECLAIM_RST;
            reclose_mask_q <= `ARP_MASK4_RST;
            inhibit_mask_q <= `ARP_MASK4_RST;
            irq_en_q       <= 4'h0;
        end else if (wr_ok) begin
            case (paddr)
                `ARP_CTRL_OFF: begin
                    ar_enable_q <= pwdata[`ARP_CTRL_ENABLE];
                    dead_mode_q <= pwdata[`ARP_CTRL_DEADMODE];
                end
                `ARP_FAST_MASK_OFF: begin
                    ph_fast_mask_q <= pwdata[`ARP_PH_MASK_LSB +: 5];
                    ef_fast_mask_q <= pwdata[`ARP_EF_MASK_LSB +: 5];
                end
                `ARP_PH_FAST_OFF: begin
                    ph_fast_dly_q <= (pwdata[9:0] > `ARP_FDLY_MAX || pwdata[31:10] != 22'h0)
                                     ? `ARP_FDLY_MAX : pwdata[9:0];
                end
                `ARP_EF_FAST_OFF: begin
                    ef_fast_dly_q <= (pwdata[9:0] > `ARP_FDLY_MAX || pwdata[31:10] != 22'h0)
                                     ? `ARP_FDLY_MAX : pwdata[9:0];
                end
                `ARP_DEAD_OFF:    dead_time_q    <= pwdata[15:0];
                `ARP_RECLAIM_OFF: reclaim_q      <= pwdata[15:0];
                `ARP_RECLOSE_OFF: reclose_mask_q <= pwdata;
                `ARP_INHIBIT_OFF: inhibit_mask_q <= pwdata;
                `ARP_IRQ_EN_OFF:  irq_en_q       <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // sticky events; a set in the clearing cycle wins over the clear
    wire [3:0] ev_vec = {ev_reset, ev_lockout, ev_reclose, trip_new};
    wire [3:0] clr_vec = (wr_ok && paddr == `ARP_IRQ_CLR_OFF) ? pwdata[3:0] : 4'h0;
    always @(posedge clk_sys) begin
        if (!resetn) begin
            irq_stat_q <= 4'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~clr_vec) | ev_vec;
        end
    end
    assign irq = |(irq_stat_q & irq_en_q);

    // read mux; write-only clear register reads zero
    always @* begin
        prdata = 32'h0000_0000;
        if (apb_rd) begin
            case (paddr)
                `ARP_CTRL_OFF:      prdata = {30'h0, dead_mode_q, ar_enable_q};
                `ARP_FAST_MASK_OFF: prdata = {19'h0, ef_fast_mask_q, 3'h0, ph_fast_mask_q};
                `ARP_PH_FAST_OFF:   prdata = {22'h0, ph_fast_dly_q};
                `ARP_EF_FAST_OFF:   prdata = {22'h0, ef_fast_dly_q};
                `ARP_DEAD_OFF:      prdata = {16'h0, dead_time_q};
                `ARP_RECLAIM_OFF:   prdata = {16'h0, reclaim_q};
                `ARP_RECLOSE_OFF:   prdata = reclose_mask_q;
                `ARP_INHIBIT_OFF:   prdata = inhibit_mask_q;
                `ARP_STATUS_OFF:    prdata = {23'h0, ar_locked, 1'b0, shot_q, 1'b0, state_q};
                `ARP_IRQ_STAT_OFF:  prdata = {28'h0, irq_stat_q};
                `ARP_IRQ_EN_OFF:    prdata = {28'h0, irq_en_q};
                default:            prdata = 32'h0000_0000;
            endcase
        end
    end

endmodule
`default_nettype wire

/* arp_shot_policy_monitor.sv */
// Purpose: port-level checker for the auto-reclose shot policy block
// Assumes: sees only the top module ports, one clock domain
// Notes:   bound into every instance of the block
`timescale 1ns/1ps
`default_nettype none
`include "arp_regs.vh"

module arp_shot_policy_mon (
    // clock and reset
    input wire        clk_sys,
    input wire        resetn,
    // apb slave side
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    // protection side
    input wire [7:0]  stage_start,
    input wire [7:0]  stage_delay_done,
    input wire        breaker_closed_aux_input,
    input wire [7:0]  stage_trip_q,
    input wire        reclose_cmd_q,
    input wire        ar_locked,
    input wire        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // a control write is the only way out of lockout, so it gates the hold check
    wire acc;
    wire ctrl_wr;
    assign acc     = psel && penable;
    assign ctrl_wr = acc && pwrite && (paddr == `ARP_CTRL_OFF);

    AST_PREADY: assert property (pready)
        else $error("pready low");
    AST_UNMAPPED: assert property (acc && paddr > 8'h2C |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_MAPPED: assert property (acc && paddr <= 8'h2C && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    AST_RECLOSE_PULSE: assert property (reclose_cmd_q |=> !reclose_cmd_q)
        else $error("reclose command longer than one cycle");
    AST_RECLOSE_UNLOCKED: assert property (reclose_cmd_q |-> !ar_locked)
        else $error("reclose while locked");
    AST_NO_CAUSE: assert property (stage_start == 8'h00 && stage_delay_done == 8'h00
        |=> stage_trip_q == 8'h00)
        else $error("trip without cause");
    AST_LOCK_HOLD: assert property (ar_locked && !ctrl_wr |=> ar_locked)
        else $error("lockout left without unlock");
    AST_LOCK_CAUSE: assert property ($rose(ar_locked) |-> stage_trip_q != 8'h00)
        else $error("lockout without trip");

    // main scenarios
    COV_RECLOSE: cover property (reclose_cmd_q);
    COV_LOCK: cover property ($rose(ar_locked));
    COV_TRIP: cover property (stage_trip_q != 8'h00);
    COV_IRQ: cover property ($rose(irq));
endmodule

bind arp_shot_policy arp_shot_policy_mon mon_u (
    .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .stage_start(stage_start), .stage_delay_done(stage_delay_done),
    .breaker_closed_aux_input(breaker_closed_aux_input), .stage_trip_q(stage_trip_q),
    .reclose_cmd_q(reclose_cmd_q), .ar_locked(ar_locked), .irq(irq)
);
`default_nettype wire

/* tb_top.sv */
// Purpose: self-checking bench for the auto-reclose shot policy block
// Assumes: zero-wait APB slave, step tick every four clocks
// Notes:   short tick keeps dead and reclaim times to a few dozen cycles
`timescale 1ns/1ps
`default_nettype none
`include "arp_regs.vh"

module tb_top;
    logic        clk_sys;
    logic        resetn;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [7:0]  stage_start;
    logic [7:0]  stage_delay_done;
    logic        brk_closed;
    wire         pready;
    wire  [31:0] prdata;
    wire         pslverr;
    wire  [7:0]  stage_trip_q;
    wire         reclose_cmd_q;
    wire         ar_locked;
    wire         irq;
    logic [31:0] rd;
    logic        err;
    integer      errors;
    integer      checks;
    integer      cyc;
    integer      i;

    // tick shortened so every sequence fits in the run
    arp_shot_policy #(.TICK_CYCLES(4)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .stage_start(stage_start), .stage_delay_done(stage_delay_done),
        .breaker_closed_aux_input(brk_closed), .stage_trip_q(stage_trip_q),
        .reclose_cmd_q(reclose_cmd_q), .ar_locked(ar_locked), .irq(irq)
    );

    // 40 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic wrap_up;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            wrap_up;
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; read data taken at the edge that completes it
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask

    task automatic pulse_done(input logic [7:0] s);
        stage_delay_done <= s;
        @(posedge clk_sys);
        stage_delay_done <= 8'h00;
        @(posedge clk_sys);
    endtask

    task automatic t_regs;
        rdchk("fast masks", `ARP_FAST_MASK_OFF, 32'h0);
        rdchk("phase delay", `ARP_PH_FAST_OFF, 32'h0);
        rdchk("reclose masks", `ARP_RECLOSE_OFF, 32'h0);
        rdchk("inhibit masks", `ARP_INHIBIT_OFF, 32'h0);
        rdchk("status", `ARP_STATUS_OFF, 32'h0);
        apb(1'b1, `ARP_PH_FAST_OFF, 32'h3E8);
        rdchk("delay clamp", `ARP_PH_FAST_OFF, 32'h3E7);
        apb(1'b1, `ARP_EF_FAST_OFF, 32'h0C);
        rdchk("earth delay", `ARP_EF_FAST_OFF, 32'h0C);
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
    endtask

    // recloser off: each stage trips straight through on its own delay
    task automatic t_plain;
        for (int s = 0; s < 8; s = s + 1) begin
            pulse_done(8'h01 << s);
            chk("plain trip", 32'h1 << s, 32'(stage_trip_q));
        end
    endtask

    task automatic t_reclose;
        apb(1'b1, `ARP_DEAD_OFF, 32'h2);
        apb(1'b1, `ARP_RECLAIM_OFF, 32'hA);
        apb(1'b1, `ARP_RECLOSE_OFF, 32'h1);
        apb(1'b1, `ARP_INHIBIT_OFF, 32'h1);
        apb(1'b1, `ARP_IRQ_EN_OFF, 32'hF);
        apb(1'b1, `ARP_CTRL_OFF, 32'h1);
        pulse_done(8'h01);
        chk("trip", 32'h1, 32'(stage_trip_q));
        brk_closed <= 1'b0;
        for (i = 0; i < 200 && reclose_cmd_q !== 1'b1; i = i + 1) @(posedge clk_sys);
        chk("reclose", 32'h1, 32'(reclose_cmd_q));
        brk_closed <= 1'b1;
        stage_delay_done <= 8'h01;
        repeat (2) @(posedge clk_sys);
        chk("inhibited", 32'h0, 32'(stage_trip_q));
        stage_delay_done <= 8'h00;
        rdchk("reclaim status", `ARP_STATUS_OFF, 32'h13);
        chk("irq on", 32'h1, 32'(irq));
        repeat (60) @(posedge clk_sys);
        rdchk("seq reset", `ARP_STATUS_OFF, 32'h0);
        rdchk("irq status", `ARP_IRQ_STAT_OFF, 32'hB);
        apb(1'b1, `ARP_IRQ_CLR_OFF, 32'hF);
        rdchk("irq cleared", `ARP_IRQ_STAT_OFF, 32'h0);
        chk("irq off", 32'h0, 32'(irq));
    endtask

    task automatic unlock;
        apb(1'b1, `ARP_CTRL_OFF, 32'h5);
        @(posedge clk_sys);
        chk("unlocked", 32'h0, 32'(ar_locked));
    endtask

    task automatic t_fast;
        apb(1'b1, `ARP_RECLOSE_OFF, 32'h0);
        apb(1'b1, `ARP_FAST_MASK_OFF, 32'h2);
        apb(1'b1, `ARP_PH_FAST_OFF, 32'h0);
        stage_start <= 8'h01;
        repeat (20) @(posedge clk_sys);
        chk("no fast first shot", 32'h0, 32'(stage_trip_q));
        apb(1'b1, `ARP_FAST_MASK_OFF, 32'h1);
        for (i = 0; i < 10 && stage_trip_q[0] !== 1'b1; i = i + 1) @(posedge clk_sys);
        chk("fast trip", 32'h1, 32'(stage_trip_q));
        stage_start <= 8'h00;
        @(posedge clk_sys);
        chk("locked", 32'h1, 32'(ar_locked));
        rdchk("lock status", `ARP_STATUS_OFF, 32'h104);
        unlock;
        // long fast delays: the shorter element delay must win
        apb(1'b1, `ARP_FAST_MASK_OFF, 32'h101);
        apb(1'b1, `ARP_PH_FAST_OFF, 32'h384);
        apb(1'b1, `ARP_EF_FAST_OFF, 32'h384);
        stage_start <= 8'h09;
        stage_delay_done <= 8'h09;
        repeat (2) @(posedge clk_sys);
        chk("shortest", 32'h9, 32'(stage_trip_q));
        stage_start <= 8'h00;
        stage_delay_done <= 8'h00;
        unlock;
        apb(1'b1, `ARP_FAST_MASK_OFF, 32'h100);
        apb(1'b1, `ARP_EF_FAST_OFF, 32'h0);
        stage_start <= 8'h08;
        for (i = 0; i < 10 && stage_trip_q[3] !== 1'b1; i = i + 1) @(posedge clk_sys);
        chk("earth fast", 32'h8, 32'(stage_trip_q));
        stage_start <= 8'h00;
        apb(1'b1, `ARP_IRQ_EN_OFF, 32'h0);
        @(posedge clk_sys);
        chk("irq masked", 32'h0, 32'(irq));
        unlock;
    endtask

    // dead time on protection reset, then a trip in reclaim advances the shot
    task automatic t_advance;
        apb(1'b1, `ARP_RECLOSE_OFF, 32'h30);
        apb(1'b1, `ARP_CTRL_OFF, 32'h3);
        stage_start <= 8'h02;
        pulse_done(8'h02);
        repeat (8) @(posedge clk_sys);
        rdchk("held by start", `ARP_STATUS_OFF, 32'h11);
        stage_start <= 8'h00;
        for (i = 0; i < 200 && reclose_cmd_q !== 1'b1; i = i + 1) @(posedge clk_sys);
        chk("start reset reclose", 32'h1, 32'(reclose_cmd_q));
        stage_start <= 8'h02;
        pulse_done(8'h02);
        rdchk("second shot", `ARP_STATUS_OFF, 32'h21);
        stage_start <= 8'h00;
        apb(1'b1, `ARP_CTRL_OFF, 32'h0);
        rdchk("disabled", `ARP_STATUS_OFF, 32'h0);
    endtask

    // main sequence
    initial begin
        errors = 0;
        checks = 0;
        cyc = 0;
        resetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        stage_start <= 8'h00;
        stage_delay_done <= 8'h00;
        brk_closed <= 1'b1;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        t_regs;
        t_plain;
        t_reclose;
        t_fast;
        t_advance;
        wrap_up;
    end
endmodule
`default_nettype wire
